// File: src/wsc_top.sv
// wait-state controller top: register slave plus bus-cycle wait sequencer
// Functional notes
// - reset loads control register with programmable mode, three waits
// - standby leaves control register unchanged; only reset reloads it
// - upper four register bits ignore writes and read as one
// - mode 00 programmable, 01 no waits, 10 pin, 11 pin auto
// - low two bits give wait count zero to three
// - waits only for external accesses by cpu or transfer controller
// - waits sit between second and third bus states
// - programmable mode inserts exactly the count on every external access
// - programmable mode ignores wait pin; pin stays a port pin
// - pin modes switch shared pin to wait input automatically
// - pin mode inserts count, then more while wait input low
// - pin mode zero count samples wait at rising edge in second state
// - auto mode samples once at falling edge in second state
// - auto mode ignores wait pin during waits and third state
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module wsc_top
  import wsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cyc_start,
  input wire logic cyc_external,
  input wire logic wait_n,
  output logic extend,
  output logic in_wait_state,
  output logic cyc_done,
  output logic wait_pin_sel,
  output logic [1:0] cfg_mode,
  output logic [1:0] cfg_count
);
  wsc_state_t state;
  wsc_state_t next_state;
  wsc_cfg_t cfg;
  wsc_req_t req;
  logic ext_q;
  logic auto_hit;
  logic [1:0] wcnt;
  logic [1:0] next_wcnt;
  logic [3:0] wcr_ctl;
  logic rise_low;
  logic fall_low;
  logic [31:0] hrdata_i;
  logic hreadyout_i;
  logic hresp_i;
  logic next_auto_hit;

  // register slave
  wsc_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .status_word({28'h0000000, in_wait_state, state}),
    .hrdata(hrdata_i),
    .hreadyout(hreadyout_i),
    .hresp(hresp_i),
    .wcr_ctl(wcr_ctl)
  );

  // wait pin samplers
  wsc_wait_filter u_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .wait_n(wait_n),
    .rise_low(rise_low),
    .fall_low(fall_low)
  );

  // field decode
  assign cfg.mode = wsc_mode_t'(wcr_ctl[WSC_MODE_HI:WSC_MODE_LO]);
  assign cfg.count = wcr_ctl[WSC_CNT_HI:WSC_CNT_LO];
  assign req.start = cyc_start;
  assign req.external = cyc_external;

  wire pin_mode = (cfg.mode == WSC_MODE_PIN);
  wire auto_mode = (cfg.mode == WSC_MODE_AUTO);
  wire prog_mode = (cfg.mode == WSC_MODE_PROG);
  wire pin_used = pin_mode | auto_mode;
  wire has_count = (cfg.count != WSC_CNT_ZERO);
  // pin mode: extra waits while pin low
  wire pin_hold = pin_mode & rise_low;
  // count waits used at the end of T2
  wire count_wait = ext_q & has_count &
                    (prog_mode | pin_mode | (auto_mode & next_auto_hit));
  wire t2_wait = count_wait | (ext_q & pin_hold);
  wire cnt_left = (wcnt != WSC_CNT_ZERO);
  wire tw_wait = cnt_left | (pin_hold & ext_q);

  // auto mode: single falling-edge sample taken in T2 only
  always_comb begin
    next_auto_hit = auto_hit;
    if (state == WSC_ST_T2) begin
      next_auto_hit = fall_low;
    end
  end

  // bus-cycle sequencer; waits go between T2 and T3
  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    case (state)
      WSC_ST_IDLE: begin
        if (req.start) begin
          next_state = WSC_ST_T1;
        end
      end
      WSC_ST_T1: begin
        next_state = WSC_ST_T2;
      end
      WSC_ST_T2: begin
        if (t2_wait) begin
          next_state = WSC_ST_TW;
          next_wcnt = count_wait ? cfg.count - WSC_CNT_ONE : WSC_CNT_ZERO;
        end else begin
          next_state = WSC_ST_T3;
        end
      end
      WSC_ST_TW: begin
        if (tw_wait) begin
          next_wcnt = cnt_left ? wcnt - WSC_CNT_ONE : WSC_CNT_ZERO;
        end else begin
          next_state = WSC_ST_T3;
        end
      end
      WSC_ST_T3: begin
        next_state = req.start ? WSC_ST_T1 : WSC_ST_IDLE;
      end
      default: begin
        next_state = WSC_ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= WSC_ST_IDLE;
      wcnt <= WSC_CNT_ZERO;
      auto_hit <= 1'b0;
    end else begin
      state <= next_state;
      wcnt <= next_wcnt;
      auto_hit <= next_auto_hit;
    end
  end

  // external flag captured at cycle start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else if (req.start & ((state == WSC_ST_IDLE) |
                 (state == WSC_ST_T3))) begin
      ext_q <= req.external;
    end
  end

  // registered outputs to the sequencer and pin mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extend <= 1'b0;
      in_wait_state <= 1'b0;
      cyc_done <= 1'b0;
      wait_pin_sel <= 1'b0;
      cfg_mode <= WSC_WCR_RESET[WSC_MODE_HI:WSC_MODE_LO];
      cfg_count <= WSC_WCR_RESET[WSC_CNT_HI:WSC_CNT_LO];
    end else begin
      extend <= (next_state == WSC_ST_TW);
      in_wait_state <= (next_state == WSC_ST_TW);
      cyc_done <= (next_state == WSC_ST_T3);
      wait_pin_sel <= pin_used;
      cfg_mode <= cfg.mode;
      cfg_count <= cfg.count;
    end
  end

  // bus answers pass straight from the slave's flops
  assign hrdata = hrdata_i;
  assign hreadyout = hreadyout_i;
  assign hresp = hresp_i;
endmodule // wsc_top

// File: src/wsc_pkg.sv
// package: register map, field layout, modes and carrier types for the wsc
package wsc_pkg;
  localparam logic [15:0] WSC_WCR_OFFSET = 16'hFF10;
  localparam logic [31:0] WSC_WCR_ADDR = 32'h0000FF10;
  localparam logic [31:0] WSC_STAT_ADDR = 32'h0000FF14;
  localparam logic [7:0] WSC_WCR_RESET = 8'hF3;
  localparam logic [3:0] WSC_RSVD_ONES = 4'hF;
  localparam int WSC_MODE_HI = 3;
  localparam int WSC_MODE_LO = 2;
  localparam int WSC_CNT_HI = 1;
  localparam int WSC_CNT_LO = 0;
  localparam logic [1:0] WSC_CNT_ZERO = 2'h0;
  localparam logic [1:0] WSC_CNT_ONE = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    WSC_MODE_PROG = 2'b00,
    WSC_MODE_NONE = 2'b01,
    WSC_MODE_PIN = 2'b10,
    WSC_MODE_AUTO = 2'b11
  } wsc_mode_t;

  typedef enum logic [2:0] {
    WSC_ST_IDLE = 3'b000,
    WSC_ST_T1 = 3'b001,
    WSC_ST_T2 = 3'b010,
    WSC_ST_TW = 3'b011,
    WSC_ST_T3 = 3'b100
  } wsc_state_t;

  // decoded control fields handed to the sequencer
  typedef struct packed {
    wsc_mode_t mode;
    logic [1:0] count;
  } wsc_cfg_t;

  // one bus-cycle request from a master
  typedef struct packed {
    logic start;
    logic external;
  } wsc_req_t;
endpackage

// File: src/wsc_wait_filter.sv
// wait pin sampler: rising and falling edge samples of the wait input
`timescale 1ns/100ps
module wsc_wait_filter
  import wsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wait_n,
  output logic rise_low,
  output logic fall_low
);
  logic fall_q;

  // rising-edge sample, active high when pin is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_low <= 1'b0;
    end else begin
      rise_low <= ~wait_n;
    end
  end

  // falling-edge sample, passed straight to fall_low without retiming
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= ~wait_n;
    end
  end

  assign fall_low = fall_q;
endmodule // wsc_wait_filter

// File: src/wsc_ahb_regs.sv
// ahb-lite slave holding the wait control register and a status word
`timescale 1ns/100ps
module wsc_ahb_regs
  import wsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] status_word,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] wcr_ctl
);
  logic wr_pend;

  wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire hit_wcr = (haddr == WSC_WCR_ADDR);
  wire hit_stat = (haddr == WSC_STAT_ADDR);
  wire [31:0] rd_val = hit_wcr ? {24'h000000, WSC_RSVD_ONES, wcr_ctl} :
                       hit_stat ? status_word : 32'h00000000;

  // address phase capture; data phase completes next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take & hwrite & hit_wcr & (hsize == HSIZE_WORD);
      hrdata <= (take & ~hwrite) ? rd_val : 32'h00000000;
      hreadyout <= 1'b1; // zero wait states, always ready
      hresp <= 1'b0; // always okay
    end
  end

  // only reset reloads; standby has no effect here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcr_ctl <= WSC_WCR_RESET[3:0];
    end else if (wr_pend) begin
      wcr_ctl <= hwdata[3:0];
    end
  end

endmodule // wsc_ahb_regs

// File: tb/wsc_slow_dev.sv
// slow external device model that pulls the wait pin low from the start of an access
`timescale 1ns/100ps
module wsc_slow_dev (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cyc_start,
  input wire logic [3:0] hold,
  output logic wait_n
);
  logic [3:0] left;
  // counts down the states this device still needs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) left <= 4'h0;
    else if (cyc_start) left <= hold;
    else if (left != 4'h0) left <= left - 4'h1;
  end
  // pulled up while the device is not stretching
  assign wait_n = (left == 4'h0);
endmodule // wsc_slow_dev

// File: tb/wsc_checker.sv
// concurrent checks on the wait sequencer outputs
`timescale 1ns/100ps
module wsc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cyc_start,
  input wire logic cyc_external,
  input wire logic extend,
  input wire logic cyc_done,
  input wire logic wait_pin_sel,
  input wire logic [1:0] cfg_mode,
  input wire logic [1:0] cfg_count
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // control fields and wait sequencing
  a_reset_load: assert property (
    $rose(hresetn) |-> cfg_mode == 2'h0 && cfg_count == 2'h3)
    else $error("control fields wrong after reset");
  a_nowait_mode: assert property (
    cyc_start && cfg_mode == 2'b01 |-> ##3 cyc_done)
    else $error("wait inserted in no-wait mode");
  a_zero_prog: assert property (
    extend |-> !(cfg_mode == 2'b00 && cfg_count == 2'h0))
    else $error("wait with zero count in programmable mode");
  a_internal_nowait: assert property (
    cyc_start && !cyc_external |-> ##3 cyc_done)
    else $error("wait on internal access");
  a_ext_origin: assert property (
    $rose(extend) |-> $past(cyc_external, 3))
    else $error("wait without external access");
  a_wait_place: assert property (
    $rose(extend) |-> $past(cyc_start, 3))
    else $error("wait not after second state");
  a_prog_exact: assert property (
    $rose(extend) && cfg_mode == 2'b00 && cfg_count == 2'h3
    |-> extend [*3] ##1 cyc_done)
    else $error("programmable wait count wrong");
  a_pin_select: assert property (
    $stable(cfg_mode) |-> wait_pin_sel == cfg_mode[1])
    else $error("wait pin function mismatch");
  a_auto_bound: assert property (
    $rose(extend) && cfg_mode == 2'b11 && cfg_count == 2'h1 |=> cyc_done)
    else $error("auto mode added extra wait");
  a_done_clean: assert property (
    cyc_done |-> !extend ##1 !cyc_done)
    else $error("third state overlaps wait");
endmodule // wsc_checker
bind wsc_top wsc_checker u_chk (.hclk, .hresetn, .cyc_start, .cyc_external,
  .extend, .cyc_done, .wait_pin_sel, .cfg_mode, .cfg_count);

// File: tb/wsc_top_tb.sv
// testbench for the wait-state controller top
`timescale 1ns/100ps
module wsc_top_tb;
  import wsc_pkg::*;
  typedef struct packed {
    logic [3:0] cfg;
    logic ext;
    logic [3:0] hold;
    logic [1:0] exp;
    logic more;
  } wsc_row_t;
  // control value, access kind, device stretch, expected waits
  localparam wsc_row_t rows [11] = '{
    '{4'h1, 1'b1, 4'h0, 2'h1, 1'b0},
    '{4'h3, 1'b1, 4'h8, 2'h3, 1'b0},
    '{4'h0, 1'b1, 4'h0, 2'h0, 1'b0},
    '{4'h7, 1'b1, 4'h8, 2'h0, 1'b0},
    '{4'h3, 1'b0, 4'h0, 2'h0, 1'b0},
    '{4'h9, 1'b1, 4'h0, 2'h1, 1'b0},
    '{4'h9, 1'b1, 4'h5, 2'h1, 1'b1},
    '{4'h8, 1'b1, 4'h4, 2'h0, 1'b1},
    '{4'hD, 1'b1, 4'h0, 2'h0, 1'b0},
    '{4'hD, 1'b1, 4'h8, 2'h1, 1'b0},
    '{4'hF, 1'b1, 4'h4, 2'h3, 1'b0}};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic cyc_start = 1'b0, cyc_external = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, cfg_mode, cfg_count;
  logic [2:0] hsize = 3'h0;
  logic [3:0] hold = 4'h0;
  logic hreadyout, hresp, wait_n, extend, in_wait_state, cyc_done;
  logic wait_pin_sel;
  int err_total = 0, checks = 0, n;
  wsc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cyc_start,
    .cyc_external, .wait_n, .extend, .in_wait_state, .cyc_done,
    .wait_pin_sel, .cfg_mode, .cfg_count);
  wsc_slow_dev u_dev (.hclk, .hresetn, .cyc_start, .hold, .wait_n);
  always #10 hclk = ~hclk;
  // results and verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // single word transfer, address phase then data phase
  task ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // one bus cycle, counting wait states until the third state
  task run(input logic ext, output int w);
    @(posedge hclk);
    cyc_start <= 1'b1;
    cyc_external <= ext;
    @(posedge hclk);
    cyc_start <= 1'b0;
    w = 0;
    repeat (40) begin
      @(posedge hclk);
      if (cyc_done === 1'b1) break;
      chk(32'(in_wait_state), 32'(extend));
      if (extend === 1'b1) w++;
    end
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, WSC_WCR_ADDR, 32'h0, rd);
    chk(rd, 32'h000000F3);
    chk(32'({hreadyout, hresp}), 32'h2);
    ahb(1'b0, WSC_STAT_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, WSC_WCR_ADDR, 32'hFFFFFF5A, rd);
    ahb(1'b0, WSC_WCR_ADDR, 32'h0, rd);
    chk(rd, 32'h000000FA);
    ahb(1'b0, 32'h00000100, 32'h0, rd);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      ahb(1'b1, WSC_WCR_ADDR, {28'h0, rows[i].cfg}, rd);
      hold <= rows[i].hold;
      run(rows[i].ext, n);
      if (rows[i].more) chk(32'(n > rows[i].exp), 32'h1);
      else chk(32'(n), 32'(rows[i].exp));
      chk(32'(wait_pin_sel), 32'(rows[i].cfg[3]));
      chk(32'({cfg_mode, cfg_count}), 32'(rows[i].cfg));
    end
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, WSC_WCR_ADDR, 32'h0, rd);
    chk(rd, 32'h000000F3);
    close_out;
  end
  // watchdog against a hung handshake
  initial begin
    #100000;
    err_total++;
    close_out;
  end
endmodule // wsc_top_tb
